// File: rtl/rta_time_alarm.sv
// Real-time clock time access interlock, counters, alarm and weekday logic
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module rta_time_alarm #(
  parameter int HOLD_CNT = rta_pkg::HOLD_CYCLES,
  parameter int TICK_CNT = rta_pkg::TICK_CYCLES,
  parameter int FIRST_CNT = rta_pkg::FIRST_TICK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic timed_access_i,
  output logic [7:0] rdata_o,
  output logic alarm_irq_flag_o,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] alarm_subsecond;
    logic [7:0] alarm_second;
    logic [7:0] alarm_minute;
    logic [7:0] alarm_hour;
    logic [3:0] cmp_en;
    logic read_en;
    logic write_en;
    logic irq_flag;
    logic rtc_en;
    logic [7:0] time_subsecond;
    logic [5:0] time_second;
    logic [5:0] time_minute;
    logic [4:0] time_hour;
    logic [2:0] weekday_field;
    logic [15:0] day_count;
    logic [rta_pkg::CNT_W-1:0] tick_cnt;
    logic [rta_pkg::CNT_W-1:0] hold_cnt;
    logic tick_pending;
    logic alarmed_this_tick;
    logic [7:0] rdata;
    logic tick;
  } rta_state_t;

  rta_state_t st;
  rta_state_t next_st;

  // Compare one field; disabled counts as match, out-of-range never does
  function automatic logic field_match(input logic en, input logic [7:0] alarm,
                                       input logic [7:0] now, input logic [7:0] maxv);
    field_match = !en || ((alarm <= maxv) && (alarm == now));
  endfunction

  function automatic logic alarm_match(input rta_state_t s);
    alarm_match = field_match(s.cmp_en[3], s.alarm_subsecond, s.time_subsecond, 8'hff)
               && field_match(s.cmp_en[2], s.alarm_second, {2'h0, s.time_second}, {2'h0, rta_pkg::SEC_MAX})
               && field_match(s.cmp_en[1], s.alarm_minute, {2'h0, s.time_minute}, {2'h0, rta_pkg::MIN_MAX})
               && field_match(s.cmp_en[0], s.alarm_hour, {3'h0, s.time_hour}, {3'h0, rta_pkg::HOUR_MAX});
  endfunction

  logic access_on;
  logic access_drop;
  logic do_tick;
  logic wr_alarm;
  logic [7:0] ctl_rd;
  rta_state_t adv;

  assign access_on = st.read_en || st.write_en;
  assign ctl_rd = {st.cmp_en, st.read_en, st.write_en, st.irq_flag, st.rtc_en};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    access_drop = 1'b0;
    do_tick = 1'b0;
    wr_alarm = 1'b0;
    adv = st;

    // Tick timer runs only while the clock is enabled
    if (st.rtc_en) begin
      if (st.tick_cnt == '0) begin
        next_st.tick_cnt = rta_pkg::CNT_W'(TICK_CNT - 1);
        if (access_on) begin
          next_st.tick_pending = 1'b1;
        end else begin
          do_tick = 1'b1;
        end
      end else begin
        next_st.tick_cnt = st.tick_cnt - 1'b1;
      end
    end

    // Access window timer and automatic read and write enable drop
    if (access_on) begin
      if (st.hold_cnt == '0) begin
        next_st.write_en = 1'b0;
        next_st.read_en = 1'b0;
      end else begin
        next_st.hold_cnt = st.hold_cnt - 1'b1;
      end
    end

    // Control register write
    if (wr_i && addr_i == rta_pkg::ADDR_CLOCK_CONTROL) begin
      next_st.cmp_en = wdata_i[7:rta_pkg::CTL_CMP_LSB];
      next_st.read_en = wdata_i[rta_pkg::CTL_READ_EN];
      next_st.rtc_en = wdata_i[rta_pkg::CTL_RTC_EN];
      if (timed_access_i) begin
        next_st.write_en = wdata_i[rta_pkg::CTL_WRITE_EN];
      end
      if (!wdata_i[rta_pkg::CTL_IRQ_FLAG]) begin
        next_st.irq_flag = 1'b0;
      end
      if (!access_on && (next_st.read_en || next_st.write_en)) begin
        next_st.hold_cnt = rta_pkg::CNT_W'(HOLD_CNT - 1);
      end
    end

    // Release of the access window
    if (access_on && !next_st.read_en && !next_st.write_en) begin
      access_drop = 1'b1;
      if (next_st.tick_pending) begin
        do_tick = 1'b1;
        next_st.tick_pending = 1'b0;
      end
    end
    if (st.write_en && !next_st.write_en) begin
      next_st.tick_cnt = rta_pkg::CNT_W'(FIRST_CNT - 1);
    end

    // Time register writes while write enable is set
    if (wr_i && st.write_en) begin
      if (addr_i == rta_pkg::ADDR_TIME_SECOND) begin
        next_st.time_second = wdata_i[5:0];
      end else if (addr_i == rta_pkg::ADDR_TIME_MINUTE) begin
        next_st.time_minute = wdata_i[5:0];
      end else if (addr_i == rta_pkg::ADDR_TIME_HOUR_WEEKDAY) begin
        next_st.time_hour = wdata_i[4:0];
        next_st.weekday_field = wdata_i[7:5];
      end else if (addr_i == rta_pkg::ADDR_DAY_COUNT_LOW) begin
        next_st.day_count[7:0] = wdata_i;
      end else if (addr_i == rta_pkg::ADDR_DAY_COUNT_HIGH) begin
        next_st.day_count[15:8] = wdata_i;
      end
    end

    // Alarm registers, always writable
    if (wr_i) begin
      if (addr_i == rta_pkg::ADDR_ALARM_SUBSECOND) begin
        next_st.alarm_subsecond = wdata_i;
        wr_alarm = 1'b1;
      end else if (addr_i == rta_pkg::ADDR_ALARM_SECOND) begin
        next_st.alarm_second = wdata_i;
        wr_alarm = 1'b1;
      end else if (addr_i == rta_pkg::ADDR_ALARM_MINUTE) begin
        next_st.alarm_minute = wdata_i;
        wr_alarm = 1'b1;
      end else if (addr_i == rta_pkg::ADDR_ALARM_HOUR) begin
        next_st.alarm_hour = wdata_i;
        wr_alarm = 1'b1;
      end
    end

    // Counter advance on a tick
    if (do_tick) begin
      next_st.tick = 1'b1;
      next_st.alarmed_this_tick = 1'b0;
      adv = next_st;
      adv.time_subsecond = next_st.time_subsecond + 1'b1;
      if (next_st.time_subsecond == 8'hff) begin
        if (next_st.time_second >= rta_pkg::SEC_MAX) begin
          adv.time_second = '0;
          if (next_st.time_minute >= rta_pkg::MIN_MAX) begin
            adv.time_minute = '0;
            if (next_st.time_hour >= rta_pkg::HOUR_MAX) begin
              adv.time_hour = '0;
              adv.day_count = next_st.day_count + 1'b1;
              if (next_st.weekday_field == rta_pkg::WDAY_LAST) begin
                adv.weekday_field = rta_pkg::WDAY_FIRST;
              end else if (next_st.weekday_field != rta_pkg::WDAY_OFF) begin
                adv.weekday_field = next_st.weekday_field + 1'b1;
              end
            end else begin
              adv.time_hour = next_st.time_hour + 1'b1;
            end
          end else begin
            adv.time_minute = next_st.time_minute + 1'b1;
          end
        end else begin
          adv.time_second = next_st.time_second + 1'b1;
        end
      end
      next_st.time_subsecond = adv.time_subsecond;
      next_st.time_second = adv.time_second;
      next_st.time_minute = adv.time_minute;
      next_st.time_hour = adv.time_hour;
      next_st.weekday_field = adv.weekday_field;
      next_st.day_count = adv.day_count;
      if (next_st.cmp_en != '0 && alarm_match(next_st)) begin
        next_st.irq_flag = 1'b1;
        next_st.alarmed_this_tick = 1'b1;
      end
    end else if (wr_alarm && !st.alarmed_this_tick && next_st.cmp_en != '0
                 && alarm_match(next_st)) begin
      next_st.irq_flag = 1'b1;
      next_st.alarmed_this_tick = 1'b1;
    end

    // Subsecond cleared when write enable drops
    if (st.write_en && !next_st.write_en) begin
      next_st.time_subsecond = rta_pkg::SUBSEC_RESET;
    end

    // No compare enables: flag cleared and blocked
    if (next_st.cmp_en == '0) begin
      next_st.irq_flag = 1'b0;
    end

    // Read data, valid the cycle after the strobe
    next_st.rdata = '0;
    if (rd_i) begin
      if (addr_i == rta_pkg::ADDR_ALARM_SUBSECOND) begin
        next_st.rdata = st.alarm_subsecond;
      end else if (addr_i == rta_pkg::ADDR_ALARM_SECOND) begin
        next_st.rdata = st.alarm_second;
      end else if (addr_i == rta_pkg::ADDR_ALARM_MINUTE) begin
        next_st.rdata = st.alarm_minute;
      end else if (addr_i == rta_pkg::ADDR_ALARM_HOUR) begin
        next_st.rdata = st.alarm_hour;
      end else if (addr_i == rta_pkg::ADDR_CLOCK_CONTROL) begin
        next_st.rdata = ctl_rd;
      end else if (st.read_en && addr_i == rta_pkg::ADDR_TIME_SUBSECOND) begin
        next_st.rdata = st.time_subsecond;
      end else if (st.read_en && addr_i == rta_pkg::ADDR_TIME_SECOND) begin
        next_st.rdata = {2'h0, st.time_second};
      end else if (st.read_en && addr_i == rta_pkg::ADDR_TIME_MINUTE) begin
        next_st.rdata = {2'h0, st.time_minute};
      end else if (st.read_en && addr_i == rta_pkg::ADDR_TIME_HOUR_WEEKDAY) begin
        next_st.rdata = {st.weekday_field, st.time_hour};
      end else if (st.read_en && addr_i == rta_pkg::ADDR_DAY_COUNT_LOW) begin
        next_st.rdata = st.day_count[7:0];
      end else if (st.read_en && addr_i == rta_pkg::ADDR_DAY_COUNT_HIGH) begin
        next_st.rdata = st.day_count[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign alarm_irq_flag_o = st.irq_flag;
  assign tick_o = st.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_we_drop;
    $fell(st.write_en);
  endsequence

  chk_sub_reset_drop: assert property (s_we_drop |-> st.time_subsecond == rta_pkg::SUBSEC_RESET)
    else $error("subsecond not cleared on write enable drop");
  chk_no_tick_held: assert property (access_on |=> !st.tick || !$past(access_on) || $fell(access_on))
    else $error("tick applied during access window");
  chk_pending_replay: assert property (access_on && st.tick_pending && !next_st.read_en && !next_st.write_en
                                       |=> st.tick)
    else $error("held tick lost");
  chk_flag_cmp_off: assert property (st.cmp_en == '0 |-> !st.irq_flag)
    else $error("flag set with no compares");
  chk_flag_sticky: assert property ($fell(st.irq_flag) |-> $past(wr_i) || st.cmp_en == '0)
    else $error("flag cleared without cause");
  chk_sub_ro: assert property (wr_i && addr_i == rta_pkg::ADDR_TIME_SUBSECOND && !do_tick && !access_drop
                               |=> $stable(st.time_subsecond))
    else $error("subsecond written by software");
  chk_wday_zero: assert property (st.weekday_field == rta_pkg::WDAY_OFF && !(wr_i && st.write_en)
                                  |=> st.weekday_field == rta_pkg::WDAY_OFF)
    else $error("weekday left zero");
  chk_wday_wrap: assert property (st.tick && $past(st.weekday_field) == rta_pkg::WDAY_LAST
                                  && st.weekday_field != rta_pkg::WDAY_LAST && !$past(wr_i)
                                  |-> st.weekday_field == rta_pkg::WDAY_FIRST)
    else $error("weekday wrap wrong");
  chk_alarm_write: assert property (wr_i && addr_i == rta_pkg::ADDR_ALARM_MINUTE
                                    |=> st.alarm_minute == $past(wdata_i))
    else $error("alarm register write lost");
  chk_sec_range: assert property (st.time_second <= rta_pkg::SEC_MAX || st.write_en
                                  |=> st.time_second <= rta_pkg::SEC_MAX || st.write_en
                                  || $past(st.write_en))
    else $error("second out of range");

  // Access window and tick hand-off
  sequence s_hold_expired;
    access_on && st.hold_cnt == '0;
  endsequence

  sequence s_access_open;
    !access_on && (next_st.read_en || next_st.write_en);
  endsequence

  chk_window_close: assert property (s_hold_expired |=> (!st.read_en && !st.write_en) || $past(wr_i))
    else $error("access window left open");
  chk_window_load: assert property (s_access_open |=> st.hold_cnt == rta_pkg::CNT_W'(HOLD_CNT - 1))
    else $error("access window not loaded");
  chk_first_tick: assert property (s_we_drop |-> st.tick_cnt == rta_pkg::CNT_W'(FIRST_CNT - 1))
    else $error("first tick delay not loaded");
  chk_tick_free: assert property (st.rtc_en && !access_on && st.tick_cnt == '0 |=> st.tick)
    else $error("due tick not applied");
  chk_tick_kept: assert property (st.rtc_en && access_on && st.tick_cnt == '0 |=> st.tick_pending || st.tick)
    else $error("held tick dropped");

  // Time register writes
  chk_time_write: assert property (wr_i && st.write_en && addr_i == rta_pkg::ADDR_TIME_SECOND && !do_tick
                                   |=> st.time_second == 6'($past(wdata_i)))
    else $error("time write lost");
  chk_time_locked: assert property (wr_i && !st.write_en && addr_i == rta_pkg::ADDR_TIME_MINUTE && !do_tick
                                    |=> $stable(st.time_minute))
    else $error("time written while locked");

  // Alarm flag
  chk_one_alarm: assert property (st.alarmed_this_tick && !do_tick |=> !$rose(st.irq_flag))
    else $error("second alarm in one tick");
  chk_flag_cause: assert property ($rose(st.irq_flag) |-> st.tick || $past(wr_i))
    else $error("flag set without tick or write");
  chk_range_never: assert property (
    next_st.cmp_en == 4'h4 && next_st.alarm_second > {2'h0, rta_pkg::SEC_MAX} |=> !$rose(st.irq_flag))
    else $error("out-of-range alarm matched");

  // Day rollover
  sequence s_day_roll;
    st.tick && !$past(wr_i) && $past(st.time_hour) == rta_pkg::HOUR_MAX && st.time_hour == '0;
  endsequence

  chk_day_carry: assert property (s_day_roll |-> st.day_count == $past(st.day_count) + 16'h0001)
    else $error("day count not advanced");
  chk_wday_step: assert property (s_day_roll ##0 ($past(st.weekday_field) != rta_pkg::WDAY_OFF
                                  && $past(st.weekday_field) != rta_pkg::WDAY_LAST)
                                  |-> st.weekday_field == $past(st.weekday_field) + 3'h1)
    else $error("weekday not advanced");
endmodule

// File: include/rta_pkg.sv
// Constants, register map and field layout of the real-time clock block
package rta_pkg;
  // Register offsets (SFR addresses)
  localparam logic [7:0] ADDR_ALARM_SUBSECOND = 8'hf2;
  localparam logic [7:0] ADDR_ALARM_SECOND = 8'hf3;
  localparam logic [7:0] ADDR_ALARM_MINUTE = 8'hf4;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'hf5;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hf9;
  localparam logic [7:0] ADDR_TIME_SUBSECOND = 8'hfa;
  localparam logic [7:0] ADDR_TIME_SECOND = 8'hfb;
  localparam logic [7:0] ADDR_TIME_MINUTE = 8'hfc;
  localparam logic [7:0] ADDR_TIME_HOUR_WEEKDAY = 8'hfd;
  localparam logic [7:0] ADDR_DAY_COUNT_LOW = 8'hfe;
  localparam logic [7:0] ADDR_DAY_COUNT_HIGH = 8'hff;
  // Control register bit positions
  localparam int CTL_CMP_LSB = 4;
  localparam int CTL_READ_EN = 3;
  localparam int CTL_WRITE_EN = 2;
  localparam int CTL_IRQ_FLAG = 1;
  localparam int CTL_RTC_EN = 0;
  // Field limits
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] WDAY_OFF = 3'h0;
  localparam logic [2:0] WDAY_FIRST = 3'h1;
  localparam logic [2:0] WDAY_LAST = 3'h7;
  localparam logic [7:0] SUBSEC_RESET = 8'h00;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam real HOLD_WINDOW_MS = 1.95;
  localparam int HOLD_CYCLES = int'($floor(HOLD_WINDOW_MS * CLK_HZ / 1000.0));
  localparam real TICK_PERIOD_MS = 3.90625;
  localparam int TICK_CYCLES = int'($floor(TICK_PERIOD_MS * CLK_HZ / 1000.0));
  localparam int FIRST_TICK_CYCLES = HOLD_CYCLES;
  localparam int CNT_W = 20;
endpackage

// File: bench/testbench.sv
// Self-checking testbench of the real-time clock access, alarm and weekday logic
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam int HOLD = 20;
  localparam int TICK = 40;
  localparam int FIRST = 20;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic timed_access_i = 1'b0;
  logic [7:0] rdata_o;
  logic alarm_irq_flag_o;
  logic tick_o;
  int mismatches = 0;
  int n_compared = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  rta_time_alarm #(.HOLD_CNT(HOLD), .TICK_CNT(TICK), .FIRST_CNT(FIRST)) i_rta_time_alarm (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .timed_access_i(timed_access_i), .rdata_o(rdata_o), .alarm_irq_flag_o(alarm_irq_flag_o),
    .tick_o(tick_o));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task conclude;
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    timed_access_i <= ta;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    timed_access_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] got);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  // Waits for tick (sel 0) or alarm flag (sel 1), bounded
  task wait_hi(input bit sel, input int bound, output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while ((sel ? alarm_irq_flag_o : tick_o) !== 1'b1 && n < bound);
    if ((sel ? alarm_irq_flag_o : tick_o) !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      conclude();
    end
  endtask
  task flag_after(input int cycles, input logic exp);
    repeat (cycles) @(posedge core_clk_i);
    #1 check({7'h00, alarm_irq_flag_o}, {7'h00, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task sc_reset;
    rdc(rta_pkg::ADDR_CLOCK_CONTROL, 8'h00);
    rdc(8'h10, 8'h00);
    rdc(rta_pkg::ADDR_TIME_SECOND, 8'h00);
    check({7'h00, alarm_irq_flag_o}, 8'h00);
  endtask
  task sc_day_wrap(input logic [7:0] h_in, input logic [7:0] h_exp, input logic [7:0] day_exp);
    int n;
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h05, 1'b1);
    repeat (4) @(posedge core_clk_i);
    wr(rta_pkg::ADDR_TIME_SECOND, 8'h3b, 1'b0);
    wr(rta_pkg::ADDR_TIME_MINUTE, 8'h3b, 1'b0);
    wr(rta_pkg::ADDR_TIME_HOUR_WEEKDAY, h_in, 1'b0);
    wr(rta_pkg::ADDR_TIME_SUBSECOND, 8'h55, 1'b0);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01, 1'b1);
    wait_hi(1'b0, FIRST + 6, n);
    check((n >= FIRST - 2 && n <= FIRST + 3) ? 8'h01 : 8'h00, 8'h01);
    wait_hi(1'b0, TICK + 2, n);
    check((n >= TICK - 1 && n <= TICK + 1) ? 8'h01 : 8'h00, 8'h01);
    repeat (254) wait_hi(1'b0, TICK + 2, n);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h09, 1'b0);
    repeat (4) @(posedge core_clk_i);
    rdc(rta_pkg::ADDR_TIME_SUBSECOND, 8'h00);
    rdc(rta_pkg::ADDR_TIME_SECOND, 8'h00);
    rdc(rta_pkg::ADDR_TIME_MINUTE, 8'h00);
    rdc(rta_pkg::ADDR_TIME_HOUR_WEEKDAY, h_exp);
    rdc(rta_pkg::ADDR_DAY_COUNT_LOW, day_exp);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01, 1'b0);
  endtask
  task sc_hold;
    int n;
    wait_hi(1'b0, TICK + 2, n);
    repeat (30) @(posedge core_clk_i);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h09, 1'b0);
    repeat (12) begin
      @(posedge core_clk_i);
      #1 check({7'h00, tick_o}, 8'h00);
    end
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01, 1'b0);
    #1 check({7'h00, tick_o}, 8'h01);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h09, 1'b0);
    repeat (HOLD + 4) @(posedge core_clk_i);
    rdc(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h05, 1'b0);
    rdc(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h05, 1'b1);
    repeat (HOLD + 4) @(posedge core_clk_i);
    rdc(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h09, 1'b0);
    repeat (4) @(posedge core_clk_i);
    rdc(rta_pkg::ADDR_TIME_SUBSECOND, 8'h00);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01, 1'b0);
  endtask
  task sc_alarm;
    int n;
    logic [7:0] v;
    wr(rta_pkg::ADDR_ALARM_SUBSECOND, 8'h05, 1'b0);
    wr(rta_pkg::ADDR_ALARM_SECOND, 8'h3d, 1'b0);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h91, 1'b0);
    wait_hi(1'b1, 260 * TICK, n);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h99, 1'b0);
    flag_after(1, 1'b0);
    wr(rta_pkg::ADDR_ALARM_SUBSECOND, 8'h05, 1'b0);
    flag_after(3, 1'b0);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h91, 1'b0);
    wait_hi(1'b0, TICK + 4, n);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h99, 1'b0);
    repeat (4) @(posedge core_clk_i);
    rd(rta_pkg::ADDR_TIME_SUBSECOND, v);
    wr(rta_pkg::ADDR_ALARM_SUBSECOND, v, 1'b0);
    flag_after(3, 1'b1);
    rdc(rta_pkg::ADDR_ALARM_SUBSECOND, v);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h09, 1'b0);
    flag_after(1, 1'b0);
    wr(rta_pkg::ADDR_CLOCK_CONTROL, 8'h01, 1'b0);
    flag_after(2 * TICK, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    sc_reset();
    sc_day_wrap(8'hf7, 8'h20, 8'h01);
    sc_day_wrap(8'h17, 8'h00, 8'h02);
    sc_day_wrap(8'h57, 8'h60, 8'h03);
    sc_hold();
    sc_alarm();
    conclude();
  end
endmodule
